// [logic/pptfs_pkg.sv]
// package: constants for the port pin / timer function select block
`default_nettype none
package pptfs_pkg;
    localparam int          PPTFS_NPINS       = 3;
    localparam int          PPTFS_DW          = 8;
    localparam int          PPTFS_AW          = 2;
    // register map (word index on the plain port)
    localparam logic [1:0]  PPTFS_ADDR_DIR    = 2'h0;
    localparam logic [1:0]  PPTFS_ADDR_DATA   = 2'h1;
    localparam logic [1:0]  PPTFS_ADDR_TMR    = 2'h2;
    localparam logic [1:0]  PPTFS_ADDR_STAT   = 2'h3;
    localparam logic [7:0]  PPTFS_DIR_RST     = 8'h00;
    localparam logic [7:0]  PPTFS_DATA_RST    = 8'h00;
    localparam logic [7:0]  PPTFS_TMR_RST     = 8'h00;
    localparam logic [7:0]  PPTFS_DIR_READ    = 8'hFF;
    localparam logic [7:0]  PPTFS_UNMAPPED    = 8'h00;
    // timer control word layout
    localparam int          PPTFS_B_CMB       = 0;
    localparam int          PPTFS_B_CH3_PWM_BIT      = 1;
    localparam int          PPTFS_B_CH4_PWM_BIT      = 2;
    localparam int          PPTFS_B_EA3       = 3;
    localparam int          PPTFS_B_EB3       = 4;
    localparam int          PPTFS_B_EA4       = 5;
    localparam int          PPTFS_IO_ZERO     = 0;
    localparam logic [2:0]  PPTFS_IO_NONE     = 3'h0;
    localparam int          PPTFS_IO_TOP      = 2;
endpackage : pptfs_pkg
`default_nettype wire

// [logic/pptfs_pin_sel.sv]
// one shared pin: decides timer output, port output or port input
`default_nettype none
module pptfs_pin_sel
    import pptfs_pkg::*;
(
    input  wire logic       cmb_i,
    input  wire logic       pwm_i,
    input  wire logic       pwm_counts_i,
    input  wire logic       oe_i,
    input  wire logic [2:0] io_i,
    input  wire logic       dir_i,
    input  wire logic       port_out_i,
    input  wire logic       tmr_out_i,
    output logic            tmr_mode_o,
    output logic            cap_en_o,
    output logic            pad_o,
    output logic            pad_oe_o
);
    // pwm takes the pin only on line A; line B passes pwm_counts_i = 0
    wire io_out_sel = (io_i != PPTFS_IO_NONE) && !io_i[PPTFS_IO_TOP];
    assign tmr_mode_o = oe_i && (cmb_i || (pwm_i && pwm_counts_i)
                        || (!pwm_i && io_out_sel) || (!pwm_counts_i && io_out_sel));
    assign cap_en_o   = !cmb_i && !pwm_i && io_i[PPTFS_IO_TOP];
    assign pad_o      = tmr_mode_o ? tmr_out_i : port_out_i;
    assign pad_oe_o   = tmr_mode_o || dir_i;
endmodule : pptfs_pin_sel
`default_nettype wire

// [logic/pptfs_top.sv]
// top: port pins 0..2 shared with timer channel 3/4 capture-compare lines
// ----------------------------------------------------------------------
// Summary of operation
// - pin 1 is timer3 B output in output state, else port by direction bit
// - timer3 B capture input from pin 1 when combined=0, ch3_pwm_bit=0, io b top=1
// - B output state: enable 1 and combined=1 or io b field 001..011
// - pin 0 is timer3 A output in output state, else port by direction bit
// - timer3 A capture input from pin 0 when combined=0, ch3_pwm_bit=0, io a top=1
// - A output state: enable 1 with combined, pwm, or field 001..011
// - pin 2 uses channel 4 A bits in the same way
// - port read gives data bit when direction 1, pad level when 0
// - direction cleared by reset and hardware standby, held in software standby
// ----------------------------------------------------------------------
`default_nettype none
module pptfs_top
    import pptfs_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                hw_standby_i,
    input  wire logic [PPTFS_AW-1:0] addr_i,
    input  wire logic [PPTFS_DW-1:0] wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [PPTFS_DW-1:0] rdata_o,
    input  wire logic [2:0]          ch3_io_a_i,
    input  wire logic [2:0]          ch3_io_b_i,
    input  wire logic [2:0]          ch4_io_a_i,
    input  wire logic [2:0]          tmr_out_i,
    output logic      [2:0]          tmr_cap_o,
    input  wire logic [2:0]          pad_i,
    output logic      [2:0]          pad_o,
    output logic      [2:0]          pad_oe_o
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [PPTFS_DW-1:0] port_direction_reg_q;
    logic [PPTFS_DW-1:0] port_data_reg_q;
    logic [PPTFS_DW-1:0] tmr_ctrl_q;
    logic [PPTFS_DW-1:0] rdata_q;
    logic [2:0]          pad_q;
    logic [2:0]          pad_oe_q;
    logic [2:0]          cap_q;

    wire wr_dir  = wr_i && (addr_i == PPTFS_ADDR_DIR);
    wire wr_data = wr_i && (addr_i == PPTFS_ADDR_DATA);
    wire wr_tmr  = wr_i && (addr_i == PPTFS_ADDR_TMR);

    wire combined_mode_bit = tmr_ctrl_q[PPTFS_B_CMB];
    wire ch3_pwm_bit       = tmr_ctrl_q[PPTFS_B_CH3_PWM_BIT];
    wire ch4_pwm_bit       = tmr_ctrl_q[PPTFS_B_CH4_PWM_BIT];
    wire ch3_out_enable_a  = tmr_ctrl_q[PPTFS_B_EA3];
    wire ch3_out_enable_b  = tmr_ctrl_q[PPTFS_B_EB3];
    wire ch4_out_enable_a  = tmr_ctrl_q[PPTFS_B_EA4];

    // hardware standby clears direction; software standby is simply no write
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_direction_reg_q <= PPTFS_DIR_RST;
        end else if (hw_standby_i) begin
            port_direction_reg_q <= PPTFS_DIR_RST;
        end else if (wr_dir) begin
            port_direction_reg_q <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_data_reg_q <= PPTFS_DATA_RST;
            tmr_ctrl_q      <= PPTFS_TMR_RST;
        end else if (hw_standby_i) begin
            port_data_reg_q <= PPTFS_DATA_RST;
            tmr_ctrl_q      <= PPTFS_TMR_RST;
        end else begin
            if (wr_data) begin
                port_data_reg_q <= wdata_i;
            end
            if (wr_tmr) begin
                tmr_ctrl_q <= wdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // pin selection
    // ------------------------------------------------------------------
    logic [2:0] tmr_mode;
    logic [2:0] cap_en;
    logic [2:0] pad_d;
    logic [2:0] pad_oe_d;

    // pin 0: timer3 line A
    pptfs_pin_sel u_pin0 (
        .cmb_i        (combined_mode_bit),
        .pwm_i        (ch3_pwm_bit),
        .pwm_counts_i (1'b1),
        .oe_i         (ch3_out_enable_a),
        .io_i         (ch3_io_a_i),
        .dir_i        (port_direction_reg_q[0]),
        .port_out_i   (port_data_reg_q[0]),
        .tmr_out_i    (tmr_out_i[0]),
        .tmr_mode_o   (tmr_mode[0]),
        .cap_en_o     (cap_en[0]),
        .pad_o        (pad_d[0]),
        .pad_oe_o     (pad_oe_d[0])
    );

    // pin 1: timer3 line B, pwm does not take this pin
    pptfs_pin_sel u_pin1 (
        .cmb_i        (combined_mode_bit),
        .pwm_i        (ch3_pwm_bit),
        .pwm_counts_i (1'b0),
        .oe_i         (ch3_out_enable_b),
        .io_i         (ch3_io_b_i),
        .dir_i        (port_direction_reg_q[1]),
        .port_out_i   (port_data_reg_q[1]),
        .tmr_out_i    (tmr_out_i[1]),
        .tmr_mode_o   (tmr_mode[1]),
        .cap_en_o     (cap_en[1]),
        .pad_o        (pad_d[1]),
        .pad_oe_o     (pad_oe_d[1])
    );

    // pin 2: timer4 line A
    pptfs_pin_sel u_pin2 (
        .cmb_i        (combined_mode_bit),
        .pwm_i        (ch4_pwm_bit),
        .pwm_counts_i (1'b1),
        .oe_i         (ch4_out_enable_a),
        .io_i         (ch4_io_a_i),
        .dir_i        (port_direction_reg_q[2]),
        .port_out_i   (port_data_reg_q[2]),
        .tmr_out_i    (tmr_out_i[2]),
        .tmr_mode_o   (tmr_mode[2]),
        .cap_en_o     (cap_en[2]),
        .pad_o        (pad_d[2]),
        .pad_oe_o     (pad_oe_d[2])
    );

    // capture sees the raw pad, independent of the port data register
    wire [2:0] cap_d = cap_en & pad_i;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    wire [PPTFS_DW-1:0] pad_level = {{(PPTFS_DW-3){1'b0}}, pad_i};
    wire [PPTFS_DW-1:0] port_rd   = (port_direction_reg_q & port_data_reg_q)
                                  | (~port_direction_reg_q & pad_level);
    wire [PPTFS_DW-1:0] stat_rd   = {{(PPTFS_DW-6){1'b0}}, cap_en, tmr_mode};
    wire [PPTFS_DW-1:0] rd_mux    = (addr_i == PPTFS_ADDR_DIR)  ? PPTFS_DIR_READ :
                                    (addr_i == PPTFS_ADDR_DATA) ? port_rd :
                                    (addr_i == PPTFS_ADDR_TMR)  ? tmr_ctrl_q :
                                    (addr_i == PPTFS_ADDR_STAT) ? stat_rd :
                                    PPTFS_UNMAPPED;

    // outputs registered: pins change one cycle after the controls
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q  <= PPTFS_UNMAPPED;
            pad_q    <= 3'h0;
            pad_oe_q <= 3'h0;
            cap_q    <= 3'h0;
        end else begin
            rdata_q  <= rd_i ? rd_mux : PPTFS_UNMAPPED;
            pad_q    <= pad_d;
            pad_oe_q <= pad_oe_d;
            cap_q    <= cap_d;
        end
    end

    assign rdata_o   = rdata_q;
    assign pad_o     = pad_q;
    assign pad_oe_o  = pad_oe_q;
    assign tmr_cap_o = cap_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    pin1_timer_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch3_out_enable_b && combined_mode_bit)
        |=> (pad_oe_o[1] && pad_o[1] == $past(tmr_out_i[1])))
        else $error("pin 1 not timer output in combined mode");
    pin1_field_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch3_out_enable_b && !combined_mode_bit && ch3_io_b_i != 3'h0 && !ch3_io_b_i[2])
        |=> (pad_oe_o[1] && pad_o[1] == $past(tmr_out_i[1])))
        else $error("pin 1 not timer output for compare field");
    pin1_port_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ch3_out_enable_b && port_direction_reg_q[1])
        |=> (pad_oe_o[1] && pad_o[1] == $past(port_data_reg_q[1])))
        else $error("pin 1 not port output");
    pin1_port_in_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ch3_out_enable_b && !port_direction_reg_q[1])
        |=> !pad_oe_o[1])
        else $error("pin 1 driven while port input");
    b_port_state_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!combined_mode_bit && ch3_io_b_i == 3'h0 && !port_direction_reg_q[1])
        |=> !pad_oe_o[1])
        else $error("pin 1 driven in port input state");
    b_field_top_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!combined_mode_bit && ch3_io_b_i[2] && !port_direction_reg_q[1])
        |=> !pad_oe_o[1])
        else $error("pin 1 driven with capture field selected");
    pin1_cap_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!combined_mode_bit && !ch3_pwm_bit && ch3_io_b_i[2])
        |=> tmr_cap_o[1] == $past(pad_i[1]))
        else $error("pin 1 capture not connected");
    pin1_cap_off_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (combined_mode_bit || ch3_pwm_bit || !ch3_io_b_i[2])
        |=> !tmr_cap_o[1])
        else $error("pin 1 capture active while disconnected");
    pin0_combined_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch3_out_enable_a && combined_mode_bit)
        |=> (pad_oe_o[0] && pad_o[0] == $past(tmr_out_i[0])))
        else $error("pin 0 not timer output in combined mode");
    pin0_pwm_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch3_out_enable_a && ch3_pwm_bit)
        |=> pad_oe_o[0])
        else $error("pin 0 not timer output under pwm");
    pin0_field_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch3_out_enable_a && !combined_mode_bit && !ch3_pwm_bit
            && ch3_io_a_i != 3'h0 && !ch3_io_a_i[2])
        |=> (pad_oe_o[0] && pad_o[0] == $past(tmr_out_i[0])))
        else $error("pin 0 not timer output for compare field");
    a_port_state_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!combined_mode_bit && !ch3_pwm_bit && (ch3_io_a_i == 3'h0 || ch3_io_a_i[2])
            && !port_direction_reg_q[0])
        |=> !pad_oe_o[0])
        else $error("pin 0 driven in port input state");
    pin0_port_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ch3_out_enable_a && port_direction_reg_q[0])
        |=> (pad_oe_o[0] && pad_o[0] == $past(port_data_reg_q[0])))
        else $error("pin 0 not port output");
    pin0_port_in_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ch3_out_enable_a && !port_direction_reg_q[0])
        |=> !pad_oe_o[0])
        else $error("pin 0 driven while port input");
    pin0_cap_on_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!combined_mode_bit && !ch3_pwm_bit && ch3_io_a_i[2])
        |=> tmr_cap_o[0] == $past(pad_i[0]))
        else $error("pin 0 capture not connected");
    pin0_cap_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch3_pwm_bit)
        |=> !tmr_cap_o[0])
        else $error("pin 0 capture active under pwm");
    pin2_timer_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch4_out_enable_a && (combined_mode_bit || ch4_pwm_bit))
        |=> (pad_oe_o[2] && pad_o[2] == $past(tmr_out_i[2])))
        else $error("pin 2 not timer output in combined or pwm mode");
    pin2_field_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch4_out_enable_a && !combined_mode_bit && !ch4_pwm_bit
            && ch4_io_a_i != 3'h0 && !ch4_io_a_i[2])
        |=> pad_oe_o[2])
        else $error("pin 2 not timer output for compare field");
    pin2_port_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ch4_out_enable_a && port_direction_reg_q[2])
        |=> (pad_oe_o[2] && pad_o[2] == $past(port_data_reg_q[2])))
        else $error("pin 2 not port output");
    pin2_port_in_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ch4_out_enable_a && !port_direction_reg_q[2])
        |=> !pad_oe_o[2])
        else $error("pin 2 driven while port input");
    pin2_cap_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!combined_mode_bit && !ch4_pwm_bit && ch4_io_a_i[2])
        |=> tmr_cap_o[2] == $past(pad_i[2]))
        else $error("pin 2 capture not connected");
    pin2_cap_off_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (combined_mode_bit || ch4_pwm_bit || !ch4_io_a_i[2])
        |=> !tmr_cap_o[2])
        else $error("pin 2 capture active while disconnected");
    port_read_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == PPTFS_ADDR_DATA && !port_direction_reg_q[0])
        |=> rdata_o[0] == $past(pad_i[0]))
        else $error("port read of input pin not pad level");
    port_read_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == PPTFS_ADDR_DATA && port_direction_reg_q[1])
        |=> rdata_o[1] == $past(port_data_reg_q[1]))
        else $error("port read of output pin not data bit");
    dir_read_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == PPTFS_ADDR_DIR)
        |=> rdata_o == PPTFS_DIR_READ)
        else $error("direction read not all ones");
    rdata_idle_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!rd_i)
        |=> rdata_o == PPTFS_UNMAPPED)
        else $error("read data not idle without a read");
    dir_standby_a: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        hw_standby_i
        |=> port_direction_reg_q == PPTFS_DIR_RST)
        else $error("direction not cleared in hardware standby");
endmodule : pptfs_top
`default_nettype wire

// [verif/pptfs_board_model.sv]
// board side of the three shared pins: resolves the pad level seen by the device
`default_nettype none
module pptfs_board_model (
    input  wire logic [2:0] pad_o_i,
    input  wire logic [2:0] pad_oe_i,
    input  wire logic [2:0] board_i,
    output logic      [2:0] pad_lvl_o
);
    // the board always drives a released pin, so no level is left floating
    assign pad_lvl_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & board_i);
endmodule : pptfs_board_model
`default_nettype wire

// [verif/pptfs_top_test.sv]
// testbench: random pin-function mixes checked through port and status reads
`default_nettype none
module pptfs_top_test
    import pptfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] rd; logic [2:0] oe; logic [2:0] po; logic [2:0] cap;} pptfs_note_s;
    logic       ref_clk_i;
    logic       rst_n_i;
    logic       hw_standby_i;
    logic       wr_i;
    logic       rd_i;
    logic       rd_hit_q = 1'b0;
    logic [1:0] addr_i;
    logic [7:0] wdata_i, rdata_o, dir_m, data_m, ctl_m;
    logic [2:0] ch3_io_a, ch3_io_b, ch4_io_a, tmr_out, tmr_cap, pad_lvl, pad_o, pad_oe, board;
    pptfs_note_s notes[$];
    int         failures, cmp_count;

    pptfs_top uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hw_standby_i(hw_standby_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ch3_io_a_i(ch3_io_a), .ch3_io_b_i(ch3_io_b), .ch4_io_a_i(ch4_io_a),
        .tmr_out_i(tmr_out), .tmr_cap_o(tmr_cap), .pad_i(pad_lvl), .pad_o(pad_o),
        .pad_oe_o(pad_oe));
    pptfs_board_model board_m (.pad_o_i(pad_o), .pad_oe_i(pad_oe), .board_i(board),
        .pad_lvl_o(pad_lvl));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------------------------------------
    // expected values, from the bench's own copy of the registers
    // ----------------------------------------------------------------------
    function automatic pptfs_note_s exp_note(input logic [1:0] a);
        pptfs_note_s n;
        logic [2:0]  io [3];
        logic [2:0]  ts, cp, lvl;
        logic        pw;
        io[0] = ch3_io_a;
        io[1] = ch3_io_b;
        io[2] = ch4_io_a;
        for (int i = 0; i < 3; i++) begin
            pw = (i == 2) ? ctl_m[2] : ctl_m[1];
            // pin 1 output state ignores the pwm bit
            ts[i] = ctl_m[3+i] & (ctl_m[0] | (pw & (i != 1)) | (io[i] != 3'h0 & !io[i][2]));
            cp[i] = !ctl_m[0] & !pw & io[i][2];
            n.oe[i] = ts[i] | dir_m[i];
            n.po[i] = ts[i] ? tmr_out[i] : data_m[i];
            lvl[i] = n.oe[i] ? n.po[i] : board[i];
        end
        n.cap = cp & lvl;
        case (a)
            2'h0: n.rd = PPTFS_DIR_READ;
            2'h1: n.rd = (data_m & dir_m) | ({5'h00, lvl} & ~dir_m);
            2'h2: n.rd = ctl_m;
            default: n.rd = {2'h0, cp, ts};
        endcase
        return n;
    endfunction : exp_note

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        notes.push_back(exp_note(a));
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
    endtask : rd

    task automatic end_sim();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------------
    // monitor: read data and pins are judged in the cycle after the strobe
    // ----------------------------------------------------------------------
    always @(posedge ref_clk_i) rd_hit_q <= rd_i;
    always @(negedge ref_clk_i) begin : mon
        pptfs_note_s n;
        if (rd_hit_q === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            check("rdata", rdata_o, n.rd);
            check("pad_oe", {5'h00, pad_oe}, {5'h00, n.oe});
            check("pad_o", {5'h00, pad_o & n.oe}, {5'h00, n.po & n.oe});
            check("tmr_cap", {5'h00, tmr_cap}, {5'h00, n.cap});
        end
    end

    initial begin
        repeat (30000) @(posedge ref_clk_i);
        failures++;
        end_sim();
    end

    initial begin
        {rst_n_i, hw_standby_i, addr_i, wdata_i, wr_i, rd_i} = '0;
        {ch3_io_a, ch3_io_b, ch4_io_a, tmr_out, board, dir_m, data_m, ctl_m} = '0;
        void'($urandom(32'h119a9144));
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int k = 0; k < 4; k++) rd(k[1:0]);
        wr(PPTFS_ADDR_STAT, 8'hFF);
        rd(PPTFS_ADDR_STAT);
        for (int t = 0; t < 400; t++) begin
            if (t % 50 == 25) begin
                // hardware standby clears direction, data and timer control
                @(posedge ref_clk_i);
                hw_standby_i <= 1'b1;
                @(posedge ref_clk_i);
                hw_standby_i <= 1'b0;
                {dir_m, data_m, ctl_m} = '0;
            end else begin
                dir_m = 8'($urandom);
                data_m = 8'($urandom);
                ctl_m = 8'($urandom) & 8'h3F;
                wr(PPTFS_ADDR_DIR, dir_m);
                wr(PPTFS_ADDR_DATA, data_m);
                wr(PPTFS_ADDR_TMR, ctl_m);
            end
            @(posedge ref_clk_i);
            {ch3_io_a, ch3_io_b, ch4_io_a, tmr_out, board} <= 15'($urandom);
            repeat (2) @(posedge ref_clk_i);
            rd(PPTFS_ADDR_DATA);
            rd(PPTFS_ADDR_STAT);
            rd(PPTFS_ADDR_TMR);
        end
        repeat (3) @(posedge ref_clk_i);
        end_sim();
    end
endmodule : pptfs_top_test
`default_nettype wire
